/* inc/sdpc_pkg.sv */
// Contract
// - After reset the second I/O rail pins stay isolated until software releases them.
// - After reset the USB transceiver functions stay isolated until their release bit is set.
// - A monitor compares the second I/O rail with three quarters of the reference.
// - A monitor compares the transceiver supply with the full internal reference.
// - After any system reset, backup domain writes are blocked until unlocked.
// - With main supply present and charging on, charge through 5k or 1.5k path.
// - Charging starts on its enable bit and stops while running from the battery.
// - Backup switch stays on battery during startup delay and after power-down reset.
// - On battery, the three backup pins serve only the clock or slow oscillator.
// - Both core regulators leave every reset enabled.
// - Run, sleep and shallow stop keep both regulators on, main one feeding core.
// - Low-power run, low-power sleep and deeper stops: main off, low-power feeds core.
// - Standby with retention: main off, low-power regulator powers only the retained SRAM.
// - Standby without retention: both regulators off, core state lost.
// - Shutdown turns both regulators off; leaving it raises a power-on reset.
// - Three voltage ranges; software keeps clock within 110, 80 or 26 MHz.
// - Lowest range slows flash reads and refuses flash write and erase.
// - Ranges 0 and 1 bypass converter at low main supply, high-power mode otherwise.
package sdpc_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
  localparam logic [7:0] OFS_CTRL_FOUR  = 8'h0c;
  localparam logic [7:0] OFS_STATUS     = 8'h10;

  // Power control one fields.
  localparam int BIT_UNLOCK   = 0;
  localparam int BIT_LPMS_LO  = 1;
  localparam int BIT_LPRUN    = 4;
  localparam int BIT_RANGE_LO = 5;

  // Power control two, three and four fields.
  localparam int BIT_IO2_REL  = 0;
  localparam int BIT_USB_REL  = 1;
  localparam int BIT_RETAIN   = 0;
  localparam int BIT_CHG_EN   = 0;
  localparam int BIT_CHG_RES  = 1;
  localparam int BIT_BYP_REQ  = 2;

  // Status fields.
  localparam int BIT_ST_IO2_MON = 0;
  localparam int BIT_ST_USB_MON = 1;
  localparam int BIT_ST_ON_BAT  = 2;
  localparam int BIT_ST_MR      = 3;
  localparam int BIT_ST_LPR     = 4;
  localparam int BIT_ST_BYPASS  = 5;
  localparam int BIT_ST_MODE_LO = 8;

  // Reset values.
  localparam logic [1:0] RANGE_RESET = 2'h1;
  localparam logic [2:0] LPMS_RESET  = 3'h0;

  // Voltage ranges and deep low-power selections.
  localparam logic [1:0] RANGE_ZERO = 2'h0;
  localparam logic [1:0] RANGE_TWO  = 2'h2;
  localparam logic [2:0] LPMS_STOP0 = 3'h0;
  localparam logic [2:0] LPMS_STOP1 = 3'h1;
  localparam logic [2:0] LPMS_STOP2 = 3'h2;
  localparam logic [2:0] LPMS_STBY  = 3'h3;
  localparam logic [2:0] LPMS_SHUT  = 3'h4;

  typedef enum logic [3:0] {
    ST_RUN, ST_SLEEP, ST_STOP0, ST_LPRUN, ST_LPSLEEP,
    ST_STOP1, ST_STOP2, ST_STANDBY, ST_SHUTDOWN
  } sdpc_state_type;

  // Regulator controls carried together.
  typedef struct packed {
    logic mr_en;
    logic lpr_en;
    logic sram2_only;
    logic core_on;
  } sdpc_reg_type;

endpackage

/* test/sdpc_properties.sv */
`timescale 1ns/1ps
module sdpc_properties (
  // Clock and reset
  input wire logic                   CLK,
  input wire logic                   RESET,
  // Register bus
  input wire logic [7:0]             AVS_ADDRESS,
  input wire logic                   AVS_READ,
  input wire logic                   AVS_WRITE,
  input wire logic                   AVS_WAITREQUEST,
  // Rails and backup domain
  input wire logic                   IO2_RAIL_ISOLATE,
  input wire logic                   BATTERY_CHARGE_ON,
  input wire logic                   BACKUP_SWITCH_ON_BATTERY,
  input wire logic                   BACKUP_PINS_RTC_ONLY,
  // Regulators and converter
  input wire sdpc_pkg::sdpc_reg_type REGULATORS,
  input wire logic [1:0]             VOLTAGE_RANGE,
  input wire logic                   FLASH_SLOW_READ,
  input wire logic                   FLASH_PROGRAM_BLOCK,
  input wire logic                   CONVERTER_BYPASS,
  input wire logic                   CONVERTER_HIGH_POWER,
  input wire logic                   POWER_ON_RESET_REQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  ////////////////////////////////////////////////////////////////////////////////
  sequence bus_request;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence answer_pulse;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  wait_answer_a: assert property (bus_request |=> answer_pulse)
    else $error("waitrequest did not answer with a single low cycle");
  io2_release_a: assert property ($fell(IO2_RAIL_ISOLATE) |-> $past(AVS_WRITE, 2)
    && $past(AVS_ADDRESS, 2) == sdpc_pkg::OFS_CTRL_TWO)
    else $error("io2 rail released without a control write");
  regs_reset_a: assert property ($fell(RESET) |-> REGULATORS.mr_en && REGULATORS.lpr_en
    && VOLTAGE_RANGE == sdpc_pkg::RANGE_RESET)
    else $error("regulators not enabled after reset");
  backup_pins_a: assert property (BACKUP_PINS_RTC_ONLY == BACKUP_SWITCH_ON_BATTERY)
    else $error("backup pins not tied to battery mode");
  charge_gate_a: assert property (BATTERY_CHARGE_ON |-> !BACKUP_SWITCH_ON_BATTERY)
    else $error("charging while on battery");
  flash_range_a: assert property (FLASH_SLOW_READ == (VOLTAGE_RANGE == sdpc_pkg::RANGE_TWO)
    && FLASH_PROGRAM_BLOCK == FLASH_SLOW_READ)
    else $error("flash limits do not follow the lowest range");
  converter_mode_a: assert property (CONVERTER_HIGH_POWER ==
    (!CONVERTER_BYPASS && VOLTAGE_RANGE != sdpc_pkg::RANGE_TWO))
    else $error("converter high power mode wrong");
  retention_regs_a: assert property (REGULATORS.sram2_only |-> !REGULATORS.mr_en
    && REGULATORS.lpr_en && !REGULATORS.core_on)
    else $error("retention standby regulators wrong");
  lowpower_core_a: assert property (REGULATORS.core_on && !REGULATORS.mr_en
    |-> REGULATORS.lpr_en)
    else $error("core powered with no regulator");
  por_pulse_a: assert property ($rose(POWER_ON_RESET_REQ)
    |-> (!$past(REGULATORS.mr_en) && !$past(REGULATORS.lpr_en)) ##1 !POWER_ON_RESET_REQ)
    else $error("power-on reset request not a pulse after shutdown");
endmodule

bind sdpc_top sdpc_properties sdpc_properties_inst (
  .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IO2_RAIL_ISOLATE(IO2_RAIL_ISOLATE), .BATTERY_CHARGE_ON(BATTERY_CHARGE_ON),
  .BACKUP_SWITCH_ON_BATTERY(BACKUP_SWITCH_ON_BATTERY),
  .BACKUP_PINS_RTC_ONLY(BACKUP_PINS_RTC_ONLY), .REGULATORS(REGULATORS),
  .VOLTAGE_RANGE(VOLTAGE_RANGE), .FLASH_SLOW_READ(FLASH_SLOW_READ),
  .FLASH_PROGRAM_BLOCK(FLASH_PROGRAM_BLOCK), .CONVERTER_BYPASS(CONVERTER_BYPASS),
  .CONVERTER_HIGH_POWER(CONVERTER_HIGH_POWER), .POWER_ON_RESET_REQ(POWER_ON_RESET_REQ)
);

/* test/sdpc_top_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module sdpc_top_test;
  localparam logic [7:0] A_ONE = sdpc_pkg::OFS_CTRL_ONE;
  localparam logic [7:0] A_TWO = sdpc_pkg::OFS_CTRL_TWO;
  localparam logic [7:0] A_THR = sdpc_pkg::OFS_CTRL_THREE;
  localparam logic [7:0] A_FOU = sdpc_pkg::OFS_CTRL_FOUR;
  localparam logic [7:0] A_STA = sdpc_pkg::OFS_STATUS;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rdq = 1'b0;
  logic        wrq = 1'b0;
  logic [3:0]  be = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic        wait_req, io2_mon = 1'b1, usb_mon = 1'b0, present = 1'b1, low = 1'b0;
  logic        power_down_reset_detect = 1'b0, startup = 1'b0, wakeup = 1'b0, entry = 1'b0, deep = 1'b0;
  logic        io2_iso, usb_iso, bk_wr, chg_on, chg_low, on_bat, pins_rtc, seen;
  logic [1:0]  range;
  logic        slow, block, bypass, high_pw, por;
  sdpc_pkg::sdpc_reg_type regs;
  int          num_errors = 0;
  int          checks = 0;
  // Mode table: control one, retention, deep request, expected regulators.
  logic [7:0]  m_ctl [8] = '{8'h20, 8'h20, 8'h22, 8'h24, 8'h30, 8'h26, 8'h26, 8'h28};
  logic        m_ret [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic        m_deep [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [3:0]  m_regs [8] = '{4'hd, 4'hd, 4'h5, 4'h5, 4'h5, 4'h6, 4'h0, 4'h0};
  logic [2:0]  bat_cases [3] = '{3'b000, 3'b110, 3'b101};

  always #2.5 clk = ~clk;

  sdpc_top sdpc_top_inst (
    .CLK(clk), .RESET(reset), .AVS_ADDRESS(adr), .AVS_READ(rdq), .AVS_WRITE(wrq),
    .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_req), .IO2_RAIL_MONITOR_ABOVE(io2_mon),
    .USB_RAIL_MONITOR_ABOVE(usb_mon), .MAIN_SUPPLY_PRESENT(present),
    .MAIN_SUPPLY_LOW(low), .POWER_DOWN_RESET_DETECT(power_down_reset_detect),
    .STARTUP_TEMPORIZATION(startup), .WAKEUP(wakeup), .CORE_SLEEP_ENTRY(entry),
    .CORE_SLEEP_DEEP(deep), .IO2_RAIL_ISOLATE(io2_iso), .USB_RAIL_ISOLATE(usb_iso),
    .BACKUP_WRITE_ENABLE(bk_wr), .BATTERY_CHARGE_ON(chg_on),
    .CHARGE_PATH_LOW_RES(chg_low), .BACKUP_SWITCH_ON_BATTERY(on_bat),
    .BACKUP_PINS_RTC_ONLY(pins_rtc), .REGULATORS(regs), .VOLTAGE_RANGE(range),
    .FLASH_SLOW_READ(slow), .FLASH_PROGRAM_BLOCK(block), .CONVERTER_BYPASS(bypass),
    .CONVERTER_HIGH_POWER(high_pw), .POWER_ON_RESET_REQ(por)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Outputs are looked at mid-cycle so no edge update races the comparison.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    wrq  <= wr;
    rdq  <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    rd = rdat;
    wrq <= 1'b0;
    rdq <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      $display("Error waitrequest expected 0 seen timeout");
      stop_test();
    end
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(n, e, rd);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    settle(4);
    `CHK("io2 isolate", 1'b1, io2_iso);
    `CHK("usb isolate", 1'b1, usb_iso);
    `CHK("backup write", 1'b0, bk_wr);
    `CHK("regulators", 4'hd, regs);
    rd_chk("ctrl one", A_ONE, 32'h20);
    rd_chk("ctrl two", A_TWO, 32'h0);
    rd_chk("ctrl three", A_THR, 32'h0);
    rd_chk("ctrl four", A_FOU, 32'h0);
    rd_chk("status", A_STA, 32'h19);
    // The transceiver supply is shown present before anything tries to release it.
    @(posedge clk);
    usb_mon <= 1'b1;
    settle(4);
    rd_chk("usb monitor", A_STA, 32'h1b);
    bus(1'b1, 8'h40, 32'hff);
    rd_chk("unmapped", 8'h40, 32'h0);
    @(posedge clk);
    be <= 4'h0;
    bus(1'b1, A_TWO, 32'h3);
    be <= 4'hf;
    settle(2);
    `CHK("io2 masked", 1'b1, io2_iso);
    bus(1'b1, A_TWO, 32'h1);
    settle(2);
    `CHK("io2 release", 1'b0, io2_iso);
    `CHK("usb still", 1'b1, usb_iso);
    bus(1'b1, A_TWO, 32'h3);
    bus(1'b1, A_ONE, 32'h21);
    settle(2);
    `CHK("usb release", 1'b0, usb_iso);
    `CHK("backup unlock", 1'b1, bk_wr);
    bus(1'b1, A_FOU, 32'h1);
    settle(2);
    `CHK("charge on", 1'b1, chg_on);
    `CHK("path 5k", 1'b0, chg_low);
    bus(1'b1, A_FOU, 32'h3);
    settle(2);
    `CHK("path 1k5", 1'b1, chg_low);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {present, startup, power_down_reset_detect} <= bat_cases[k];
      settle(4);
      `CHK("on battery", 1'b1, on_bat);
      `CHK("pins rtc", 1'b1, pins_rtc);
      `CHK("charge gated", 1'b0, chg_on);
      @(posedge clk);
      {present, startup, power_down_reset_detect} <= 3'b100;
      settle(4);
      `CHK("on main", 1'b0, on_bat);
      `CHK("charge back", 1'b1, chg_on);
    end
    for (int r = 0; r < 3; r++) begin
      bus(1'b1, A_ONE, 32'h01 | (r << 5));
      settle(2);
      `CHK("range", r, range);
      `CHK("flash slow", r == 2, slow);
      `CHK("flash block", r == 2, block);
      @(posedge clk);
      low <= 1'b1;
      settle(4);
      `CHK("auto bypass", r != 2, bypass);
      @(posedge clk);
      low <= 1'b0;
      settle(4);
      `CHK("high power", r != 2, high_pw);
    end
    bus(1'b1, A_FOU, 32'h7);
    settle(2);
    `CHK("soft bypass", 1'b1, bypass);
    bus(1'b1, A_ONE, 32'h61);
    rd_chk("range three", A_ONE, 32'h41);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, A_THR, {31'h0, m_ret[i]});
      bus(1'b1, A_ONE, {24'h0, m_ctl[i]});
      @(posedge clk);
      deep  <= m_deep[i];
      entry <= 1'b1;
      @(posedge clk);
      entry <= 1'b0;
      settle(2);
      `CHK("mode regulators", m_regs[i], regs);
      @(posedge clk);
      wakeup <= 1'b1;
      seen = 1'b0;
      for (int k = 0; k < 12; k++) begin
        @(posedge clk);
        seen = seen | (por === 1'b1);
        if (k == 3) wakeup <= 1'b0;
      end
      `CHK("por request", m_ctl[i] == 8'h28, seen);
    end
    settle(2);
    `CHK("woken regs", 4'hd, regs);
    `CHK("io2 isolated again", 1'b1, io2_iso);
    rd_chk("ctrl one cleared", A_ONE, 32'h20);
    rd_chk("ctrl four cleared", A_FOU, 32'h0);
    stop_test();
  end
endmodule

/* verilog/sdpc_top.sv */
`timescale 1ns/1ps
module sdpc_top (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Analog status pins
  input  wire logic        IO2_RAIL_MONITOR_ABOVE,
  input  wire logic        USB_RAIL_MONITOR_ABOVE,
  input  wire logic        MAIN_SUPPLY_PRESENT,
  input  wire logic        MAIN_SUPPLY_LOW,
  input  wire logic        POWER_DOWN_RESET_DETECT,
  input  wire logic        STARTUP_TEMPORIZATION,
  input  wire logic        WAKEUP,
  // Core low-power requests, same clock
  input  wire logic        CORE_SLEEP_ENTRY,
  input  wire logic        CORE_SLEEP_DEEP,
  // Rail isolation and backup domain
  output logic             IO2_RAIL_ISOLATE,
  output logic             USB_RAIL_ISOLATE,
  output logic             BACKUP_WRITE_ENABLE,
  output logic             BATTERY_CHARGE_ON,
  output logic             CHARGE_PATH_LOW_RES,
  output logic             BACKUP_SWITCH_ON_BATTERY,
  output logic             BACKUP_PINS_RTC_ONLY,
  // Regulators and converter
  output sdpc_pkg::sdpc_reg_type REGULATORS,
  output logic      [1:0]  VOLTAGE_RANGE,
  output logic             FLASH_SLOW_READ,
  output logic             FLASH_PROGRAM_BLOCK,
  output logic             CONVERTER_BYPASS,
  output logic             CONVERTER_HIGH_POWER,
  output logic             POWER_ON_RESET_REQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  logic [6:0] pins_meta_q;
  logic [6:0] pins_q;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pins_meta_q <= 7'h00;
      pins_q      <= 7'h00;
    end else begin
      pins_meta_q <= {IO2_RAIL_MONITOR_ABOVE, USB_RAIL_MONITOR_ABOVE, MAIN_SUPPLY_PRESENT,
                      MAIN_SUPPLY_LOW, POWER_DOWN_RESET_DETECT, STARTUP_TEMPORIZATION,
                      WAKEUP};
      pins_q      <= pins_meta_q;
    end
  end

  logic io2_mon;
  logic usb_mon;
  logic main_present;
  logic main_low;
  logic pdr_seen;
  logic startup_busy;
  logic wake;

  assign {io2_mon, usb_mon, main_present, main_low, pdr_seen, startup_busy, wake} = pins_q;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave handshake.

  // Every access takes exactly one wait cycle; a write is acted on at
  // the edge where waitrequest is seen low (reads are captured one edge earlier), so writes apply once only.
  logic       wait_q;
  logic       req;
  logic       wr_take;
  logic [7:0] wdat;

  assign req     = AVS_READ | AVS_WRITE;
  assign wr_take = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];
  assign wdat    = AVS_WRITEDATA[7:0];

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wait_q <= 1'b1;
    end else if (req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  logic       unlock_q;
  logic [2:0] lpms_q;
  logic       lprun_q;
  logic [1:0] range_q;
  logic       io2_rel_q;
  logic       usb_rel_q;
  logic       retain_q;
  logic       chg_en_q;
  logic       chg_res_q;
  logic       byp_req_q;
  logic       core_clear;

  // Leaving standby or shutdown repowers the core domain, so these reload.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      unlock_q <= 1'b0;
      lpms_q   <= sdpc_pkg::LPMS_RESET;
      lprun_q  <= 1'b0;
      range_q  <= sdpc_pkg::RANGE_RESET;
    end else if (core_clear) begin
      unlock_q <= 1'b0;
      lpms_q   <= sdpc_pkg::LPMS_RESET;
      lprun_q  <= 1'b0;
      range_q  <= sdpc_pkg::RANGE_RESET;
    end else if (wr_take && AVS_ADDRESS == sdpc_pkg::OFS_CTRL_ONE) begin
      unlock_q <= wdat[sdpc_pkg::BIT_UNLOCK];
      lpms_q   <= wdat[sdpc_pkg::BIT_LPMS_LO +: 3];
      lprun_q  <= wdat[sdpc_pkg::BIT_LPRUN];
      // The unused fourth range code is ignored so the range stays legal.
      if (wdat[sdpc_pkg::BIT_RANGE_LO +: 2] <= sdpc_pkg::RANGE_TWO) begin
        range_q <= wdat[sdpc_pkg::BIT_RANGE_LO +: 2];
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      io2_rel_q <= 1'b0;
      usb_rel_q <= 1'b0;
    end else if (core_clear) begin
      io2_rel_q <= 1'b0;
      usb_rel_q <= 1'b0;
    end else if (wr_take && AVS_ADDRESS == sdpc_pkg::OFS_CTRL_TWO) begin
      io2_rel_q <= wdat[sdpc_pkg::BIT_IO2_REL];
      usb_rel_q <= wdat[sdpc_pkg::BIT_USB_REL];
    end
  end

  // Retention and charge settings live with the standby circuitry and survive
  // a standby exit, but a shutdown exit is a full power-on reset.
  logic full_clear;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      retain_q <= 1'b0;
    end else if (full_clear) begin
      retain_q <= 1'b0;
    end else if (wr_take && AVS_ADDRESS == sdpc_pkg::OFS_CTRL_THREE) begin
      retain_q <= wdat[sdpc_pkg::BIT_RETAIN];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      chg_en_q  <= 1'b0;
      chg_res_q <= 1'b0;
      byp_req_q <= 1'b0;
    end else if (full_clear) begin
      chg_en_q  <= 1'b0;
      chg_res_q <= 1'b0;
      byp_req_q <= 1'b0;
    end else if (wr_take && AVS_ADDRESS == sdpc_pkg::OFS_CTRL_FOUR) begin
      chg_en_q  <= wdat[sdpc_pkg::BIT_CHG_EN];
      chg_res_q <= wdat[sdpc_pkg::BIT_CHG_RES];
      byp_req_q <= wdat[sdpc_pkg::BIT_BYP_REQ];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode sequencer.

  sdpc_pkg::sdpc_state_type state_q;
  sdpc_pkg::sdpc_state_type state_d;
  sdpc_pkg::sdpc_state_type awake_mode;
  sdpc_pkg::sdpc_state_type deep_mode;

  assign awake_mode = lprun_q ? sdpc_pkg::ST_LPRUN : sdpc_pkg::ST_RUN;

  always_comb begin
    case (lpms_q)
      sdpc_pkg::LPMS_STOP0: deep_mode = sdpc_pkg::ST_STOP0;
      sdpc_pkg::LPMS_STOP1: deep_mode = sdpc_pkg::ST_STOP1;
      sdpc_pkg::LPMS_STOP2: deep_mode = sdpc_pkg::ST_STOP2;
      sdpc_pkg::LPMS_STBY:  deep_mode = sdpc_pkg::ST_STANDBY;
      default:              deep_mode = sdpc_pkg::ST_SHUTDOWN;
    endcase
  end

  always_comb begin
    state_d    = state_q;
    core_clear = 1'b0;
    full_clear = 1'b0;
    case (state_q)
      sdpc_pkg::ST_RUN, sdpc_pkg::ST_LPRUN: begin
        if (CORE_SLEEP_ENTRY && CORE_SLEEP_DEEP) begin
          state_d = deep_mode;
        end else if (CORE_SLEEP_ENTRY) begin
          state_d = lprun_q ? sdpc_pkg::ST_LPSLEEP : sdpc_pkg::ST_SLEEP;
        end else begin
          state_d = awake_mode;
        end
      end
      sdpc_pkg::ST_STANDBY: begin
        if (wake) begin
          state_d    = sdpc_pkg::ST_RUN;
          core_clear = 1'b1;
        end
      end
      sdpc_pkg::ST_SHUTDOWN: begin
        if (wake) begin
          state_d    = sdpc_pkg::ST_RUN;
          core_clear = 1'b1;
          full_clear = 1'b1;
        end
      end
      default: begin
        if (wake) begin
          state_d = awake_mode;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= sdpc_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Regulator enables for the next state.
  sdpc_pkg::sdpc_reg_type reg_d;

  always_comb begin
    case (state_d)
      sdpc_pkg::ST_RUN, sdpc_pkg::ST_SLEEP, sdpc_pkg::ST_STOP0: begin
        reg_d = '{mr_en: 1'b1, lpr_en: 1'b1, sram2_only: 1'b0, core_on: 1'b1};
      end
      sdpc_pkg::ST_LPRUN, sdpc_pkg::ST_LPSLEEP, sdpc_pkg::ST_STOP1, sdpc_pkg::ST_STOP2: begin
        reg_d = '{mr_en: 1'b0, lpr_en: 1'b1, sram2_only: 1'b0, core_on: 1'b1};
      end
      sdpc_pkg::ST_STANDBY: begin
        reg_d = '{mr_en: 1'b0, lpr_en: retain_q, sram2_only: retain_q, core_on: 1'b0};
      end
      default: begin
        reg_d = '{mr_en: 1'b0, lpr_en: 1'b0, sram2_only: 1'b0, core_on: 1'b0};
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      REGULATORS <= '{mr_en: 1'b1, lpr_en: 1'b1, sram2_only: 1'b0, core_on: 1'b1};
    end else begin
      REGULATORS <= reg_d;
    end
  end

  // One-cycle power-on reset request on leaving shutdown.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      POWER_ON_RESET_REQ <= 1'b0;
    end else begin
      POWER_ON_RESET_REQ <= full_clear;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail isolation and backup domain.

  logic on_battery;

  // Battery mode when the main supply is absent, during the startup delay,
  // or after a power-down reset has been seen.
  assign on_battery = ~main_present | startup_busy | pdr_seen;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IO2_RAIL_ISOLATE <= 1'b1;
      USB_RAIL_ISOLATE <= 1'b1;
    end else begin
      IO2_RAIL_ISOLATE <= ~io2_rel_q;
      USB_RAIL_ISOLATE <= ~usb_rel_q;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      BACKUP_WRITE_ENABLE      <= 1'b0;
      BACKUP_SWITCH_ON_BATTERY <= 1'b1;
      BACKUP_PINS_RTC_ONLY     <= 1'b1;
    end else begin
      BACKUP_WRITE_ENABLE      <= unlock_q;
      BACKUP_SWITCH_ON_BATTERY <= on_battery;
      BACKUP_PINS_RTC_ONLY     <= on_battery;
    end
  end

  // Charging is gated off in battery mode without touching the enable bit,
  // so it resumes by itself once battery mode ends.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      BATTERY_CHARGE_ON   <= 1'b0;
      CHARGE_PATH_LOW_RES <= 1'b0;
    end else begin
      BATTERY_CHARGE_ON   <= chg_en_q & main_present & ~on_battery;
      CHARGE_PATH_LOW_RES <= chg_res_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage range, flash and converter.

  logic range_low;
  logic bypass_d;

  assign range_low = (range_q == sdpc_pkg::RANGE_TWO);
  assign bypass_d  = range_low ? byp_req_q : main_low;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      VOLTAGE_RANGE        <= sdpc_pkg::RANGE_RESET;
      FLASH_SLOW_READ      <= 1'b0;
      FLASH_PROGRAM_BLOCK  <= 1'b0;
      CONVERTER_BYPASS     <= 1'b0;
      CONVERTER_HIGH_POWER <= 1'b1;
    end else begin
      VOLTAGE_RANGE        <= range_q;
      FLASH_SLOW_READ      <= range_low;
      FLASH_PROGRAM_BLOCK  <= range_low;
      CONVERTER_BYPASS     <= bypass_d;
      CONVERTER_HIGH_POWER <= ~bypass_d & ~range_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (AVS_ADDRESS == sdpc_pkg::OFS_CTRL_ONE) begin
      rdata[sdpc_pkg::BIT_UNLOCK]         = unlock_q;
      rdata[sdpc_pkg::BIT_LPMS_LO +: 3]   = lpms_q;
      rdata[sdpc_pkg::BIT_LPRUN]          = lprun_q;
      rdata[sdpc_pkg::BIT_RANGE_LO +: 2]  = range_q;
    end else if (AVS_ADDRESS == sdpc_pkg::OFS_CTRL_TWO) begin
      rdata[sdpc_pkg::BIT_IO2_REL]        = io2_rel_q;
      rdata[sdpc_pkg::BIT_USB_REL]        = usb_rel_q;
    end else if (AVS_ADDRESS == sdpc_pkg::OFS_CTRL_THREE) begin
      rdata[sdpc_pkg::BIT_RETAIN]         = retain_q;
    end else if (AVS_ADDRESS == sdpc_pkg::OFS_CTRL_FOUR) begin
      rdata[sdpc_pkg::BIT_CHG_EN]         = chg_en_q;
      rdata[sdpc_pkg::BIT_CHG_RES]        = chg_res_q;
      rdata[sdpc_pkg::BIT_BYP_REQ]        = byp_req_q;
    end else if (AVS_ADDRESS == sdpc_pkg::OFS_STATUS) begin
      rdata[sdpc_pkg::BIT_ST_IO2_MON]     = io2_mon;
      rdata[sdpc_pkg::BIT_ST_USB_MON]     = usb_mon;
      rdata[sdpc_pkg::BIT_ST_ON_BAT]      = on_battery;
      rdata[sdpc_pkg::BIT_ST_MR]          = REGULATORS.mr_en;
      rdata[sdpc_pkg::BIT_ST_LPR]         = REGULATORS.lpr_en;
      rdata[sdpc_pkg::BIT_ST_BYPASS]      = CONVERTER_BYPASS;
      rdata[sdpc_pkg::BIT_ST_MODE_LO +: 4] = state_q;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && wait_q) begin
      AVS_READDATA <= rdata;
    end
  end

  assign AVS_WAITREQUEST = wait_q;

endmodule
